/* hw/flash_access_ctrl.sv */
/*
  Program Flash access controller: wait-stated reads with a prefetch buffer,
  and a program/erase engine that works on one module while the other serves reads.
  Assumes one synchronous clock and that the read master holds its request until taken.
*/
`timescale 1ns/1ps
module flash_access_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32,
  parameter int PAGE_W = 5,
  parameter int ERASE_CYCLES = flash_ctrl_pkg::ERASE_TYP_CYCLES,
  parameter int PROG_CYCLES = flash_ctrl_pkg::PROG_TYP_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Configuration
  input wire logic [3:0] flash_wait_state_count_in,
  input wire logic [7:0] sys_clk_mhz_in,
  output logic ws_too_low_out,
  // Read port
  input wire logic rd_req_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic rd_ready_out,
  output logic rd_valid_out,
  output logic [DATA_W-1:0] rd_data_out,
  // Program and erase port
  input wire logic op_req_in,
  input wire logic op_erase_in,
  input wire logic [ADDR_W-1:0] op_addr_in,
  input wire logic [DATA_W-1:0] op_data_in,
  output logic op_busy_out,
  output logic op_done_out,
  output logic op_reject_out
);

  import flash_ctrl_pkg::*;

  localparam int BANK_AW = ADDR_W - 1;
  localparam int PAGE_WORDS = 2**PAGE_W;

  // ----------------------------------------
  // Wait-state check
  // ----------------------------------------
  logic [3:0] required_wait_states;
  logic ws_low_next;

  always_comb begin
    if (sys_clk_mhz_in <= WS_LIMIT1_MHZ) begin
      required_wait_states = WS_MIN1;
    end else if (sys_clk_mhz_in <= WS_LIMIT2_MHZ) begin
      required_wait_states = WS_MIN2;
    end else if (sys_clk_mhz_in <= WS_LIMIT3_MHZ) begin
      required_wait_states = WS_MIN3;
    end else begin
      required_wait_states = WS_MIN4;
    end
    ws_low_next = flash_wait_state_count_in < required_wait_states;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ws_too_low_out <= 1'b0;
    end else begin
      ws_too_low_out <= ws_low_next;
    end
  end

  // ----------------------------------------
  // Program and erase engine
  // ----------------------------------------
  op_state_t os_reg, os_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic op_mod_reg, op_mod_next;
  logic op_erase_reg, op_erase_next;
  logic [BANK_AW-1:0] op_addr_reg, op_addr_next;
  logic [DATA_W-1:0] op_data_reg, op_data_next;
  logic busy_next, done_next, reject_next;
  logic serve_valid_reg, serve_mod_reg;
  logic op_take, op_conflict, op_start, wr_en;

  always_comb begin
    os_next = os_reg;
    timer_next = timer_reg;
    op_mod_next = op_mod_reg;
    op_erase_next = op_erase_reg;
    op_addr_next = op_addr_reg;
    op_data_next = op_data_reg;
    busy_next = op_busy_out;
    done_next = 1'b0;
    reject_next = 1'b0;
    wr_en = 1'b0;
    op_take = op_req_in && (os_reg == OP_IDLE);
    op_conflict = serve_valid_reg && (op_addr_in[ADDR_W-1] == serve_mod_reg);
    op_start = op_take && !op_conflict;
    unique case (os_reg)
      OP_IDLE: begin
        if (op_take && op_conflict) begin
          reject_next = 1'b1;
        end else if (op_start) begin
          op_mod_next = op_addr_in[ADDR_W-1];
          op_erase_next = op_erase_in;
          op_data_next = op_data_in;
          op_addr_next = op_addr_in[BANK_AW-1:0];
          if (op_erase_in) begin
            op_addr_next[PAGE_W-1:0] = '0;
            timer_next = TIMER_W'(ERASE_CYCLES - 1);
          end else begin
            timer_next = TIMER_W'(PROG_CYCLES - 1);
          end
          busy_next = 1'b1;
          os_next = OP_TIME;
        end
      end
      OP_TIME: begin
        if (timer_reg == '0) begin
          os_next = OP_WRITE;
        end else begin
          timer_next = timer_reg - 1'b1;
        end
      end
      OP_WRITE: begin
        // Erase walks the page one word a cycle after the timed interval.
        wr_en = 1'b1;
        if (!op_erase_reg || (&op_addr_reg[PAGE_W-1:0])) begin
          done_next = 1'b1;
          busy_next = 1'b0;
          os_next = OP_IDLE;
        end else begin
          op_addr_next = op_addr_reg + 1'b1;
        end
      end
      default: begin
        os_next = OP_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      os_reg <= OP_IDLE;
      timer_reg <= '0;
      op_mod_reg <= 1'b0;
      op_erase_reg <= 1'b0;
      op_addr_reg <= '0;
      op_data_reg <= '0;
      op_busy_out <= 1'b0;
      op_done_out <= 1'b0;
      op_reject_out <= 1'b0;
    end else begin
      os_reg <= os_next;
      timer_reg <= timer_next;
      op_mod_reg <= op_mod_next;
      op_erase_reg <= op_erase_next;
      op_addr_reg <= op_addr_next;
      op_data_reg <= op_data_next;
      op_busy_out <= busy_next;
      op_done_out <= done_next;
      op_reject_out <= reject_next;
    end
  end

  // ----------------------------------------
  // Read engine with prefetch
  // ----------------------------------------
  rd_state_t rs_reg, rs_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] fa_reg, fa_next, pf_addr_reg, pf_addr_next, start_addr;
  logic [DATA_W-1:0] pf_data_reg, pf_data_next, rd_data_next, cap_data;
  logic deliver_reg, deliver_next, pf_valid_reg, pf_valid_next;
  logic serve_valid_next, serve_mod_next, rd_valid_next, rd_ready_next;
  logic rd_take, rd_hit, same_fetch, blocked, issue_en, start, start_deliver;
  logic [DATA_W-1:0] bank_rdata [2];

  always_comb begin
    rs_next = rs_reg;
    cnt_next = cnt_reg;
    fa_next = fa_reg;
    deliver_next = deliver_reg;
    pf_addr_next = pf_addr_reg;
    pf_data_next = pf_data_reg;
    pf_valid_next = pf_valid_reg;
    serve_valid_next = serve_valid_reg;
    serve_mod_next = serve_mod_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_out;
    issue_en = 1'b0;
    start = 1'b0;
    start_deliver = 1'b0;
    start_addr = fa_reg;
    cap_data = bank_rdata[fa_reg[ADDR_W-1]];
    rd_take = rd_req_in && rd_ready_out;
    rd_hit = rd_take && pf_valid_reg && (rd_addr_in == pf_addr_reg);
    same_fetch = rd_take && (rs_reg != RD_IDLE) && (rd_addr_in == fa_reg);
    blocked = op_busy_out && (fa_reg[ADDR_W-1] == op_mod_reg);
    if (rd_take) begin
      serve_valid_next = 1'b1;
      serve_mod_next = rd_addr_in[ADDR_W-1];
    end
    unique case (rs_reg)
      RD_IDLE: begin
      end
      RD_WAIT: begin
        if (cnt_reg == '0) begin
          rs_next = RD_ISSUE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      RD_ISSUE: begin
        // A module under program or erase is never read; the fetch waits instead.
        if (!blocked) begin
          issue_en = 1'b1;
          rs_next = RD_CAPTURE;
        end
      end
      RD_CAPTURE: begin
        if (deliver_reg || same_fetch) begin
          rd_valid_next = 1'b1;
          rd_data_next = cap_data;
          start = 1'b1;
          start_addr = fa_reg + 1'b1;
        end else begin
          pf_valid_next = 1'b1;
          pf_addr_next = fa_reg;
          pf_data_next = cap_data;
          rs_next = RD_IDLE;
        end
      end
    endcase
    if (rd_take && rd_hit) begin
      rd_valid_next = 1'b1;
      rd_data_next = pf_data_reg;
      pf_valid_next = 1'b0;
      start = 1'b1;
      start_addr = rd_addr_in + 1'b1;
    end else if (same_fetch) begin
      deliver_next = 1'b1;
    end else if (rd_take) begin
      pf_valid_next = 1'b0;
      start = 1'b1;
      start_deliver = 1'b1;
      start_addr = rd_addr_in;
    end
    if (start) begin
      fa_next = start_addr;
      deliver_next = start_deliver;
      if (flash_wait_state_count_in == '0) begin
        rs_next = RD_ISSUE;
      end else begin
        cnt_next = flash_wait_state_count_in - 1'b1;
        rs_next = RD_WAIT;
      end
    end
    if (op_start && (pf_addr_reg[ADDR_W-1] == op_addr_in[ADDR_W-1])) begin
      pf_valid_next = 1'b0;
    end
    rd_ready_next = (rs_next == RD_IDLE) || !deliver_next;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rs_reg <= RD_IDLE;
      cnt_reg <= '0;
      fa_reg <= '0;
      deliver_reg <= 1'b0;
      pf_addr_reg <= '0;
      pf_data_reg <= '0;
      pf_valid_reg <= 1'b0;
      serve_valid_reg <= 1'b0;
      serve_mod_reg <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
      rd_ready_out <= 1'b1;
    end else begin
      rs_reg <= rs_next;
      cnt_reg <= cnt_next;
      fa_reg <= fa_next;
      deliver_reg <= deliver_next;
      pf_addr_reg <= pf_addr_next;
      pf_data_reg <= pf_data_next;
      pf_valid_reg <= pf_valid_next;
      serve_valid_reg <= serve_valid_next;
      serve_mod_reg <= serve_mod_next;
      rd_valid_out <= rd_valid_next;
      rd_data_out <= rd_data_next;
      rd_ready_out <= rd_ready_next;
    end
  end

  // ----------------------------------------
  // Flash modules
  // ----------------------------------------
  for (genvar m = 0; m < 2; m++) begin : g_bank
    logic own_op, bank_en, bank_we;
    logic [BANK_AW-1:0] bank_addr;
    assign own_op = op_busy_out && (op_mod_reg == 1'(m));
    assign bank_we = wr_en && (op_mod_reg == 1'(m));
    assign bank_en = bank_we || (issue_en && (fa_reg[ADDR_W-1] == 1'(m)));
    assign bank_addr = own_op ? op_addr_reg : fa_reg[BANK_AW-1:0];
    flash_bank_mem #(
      .AW(BANK_AW),
      .DW(DATA_W)
    ) u_mem (
      .clk_in(clk_in),
      .en_in(bank_en),
      .we_in(bank_we),
      .addr_in(bank_addr),
      .wdata_in(op_erase_reg ? {DATA_W{1'b1}} : op_data_reg),
      .rdata_out(bank_rdata[m])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Helper counters: latency of a fresh miss, and length of an operation.
  logic [7:0] lat_reg, lat_next;
  logic [3:0] ws_snap_reg, ws_snap_next;
  logic track_reg, track_next;
  int op_cnt_reg, op_cnt_next;

  always_comb begin
    lat_next = (lat_reg == 8'hFF) ? lat_reg : lat_reg + 8'h01;
    ws_snap_next = ws_snap_reg;
    track_next = track_reg && !(rs_reg == RD_ISSUE && blocked);
    op_cnt_next = op_cnt_reg + 1;
    if (rd_take) begin
      lat_next = 8'h00;
      ws_snap_next = flash_wait_state_count_in;
      track_next = (rs_reg == RD_IDLE) && !rd_hit;
    end
    if (op_start) begin
      op_cnt_next = 0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lat_reg <= 8'h00;
      ws_snap_reg <= 4'h0;
      track_reg <= 1'b0;
      op_cnt_reg <= 0;
    end else begin
      lat_reg <= lat_next;
      ws_snap_reg <= ws_snap_next;
      track_reg <= track_next;
      op_cnt_reg <= op_cnt_next;
    end
  end

  ws_fast_clock_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(sys_clk_mhz_in) > WS_LIMIT3_MHZ && $past(flash_wait_state_count_in) < WS_MIN4 |-> ws_too_low_out)
    else $error("Too few wait states not flagged.");
  miss_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_valid_out && track_reg |-> lat_reg == 8'(ws_snap_reg) + 8'(MISS_OVERHEAD))
    else $error("Miss latency differs from wait states.");
  prefetch_hit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_hit |=> rd_valid_out && rd_data_out == $past(pf_data_reg))
    else $error("Prefetch hit not answered next cycle.");
  bank_owner_a: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_en |-> !(issue_en && fa_reg[ADDR_W-1] == op_mod_reg))
    else $error("Read and write met on one module.");
  serve_reject_a: assert property (@(posedge clk_in) disable iff (rst_in)
    op_take && op_conflict |=> op_reject_out && !op_busy_out)
    else $error("Operation on serving module not refused.");
  other_accept_a: assert property (@(posedge clk_in) disable iff (rst_in)
    op_take && !op_conflict |=> op_busy_out && !op_reject_out)
    else $error("Operation on idle module not started.");
  read_busy_bank_a: assert property (@(posedge clk_in) disable iff (rst_in)
    rs_reg == RD_ISSUE && blocked && !rd_take |=> rs_reg == RD_ISSUE)
    else $error("Read issued to module under operation.");
  erase_max_a: assert property (@(posedge clk_in) disable iff (rst_in)
    op_done_out && op_erase_reg |-> op_cnt_reg <= ERASE_MAX_CYCLES)
    else $error("Erase overran its maximum time.");
  prog_max_a: assert property (@(posedge clk_in) disable iff (rst_in)
    op_done_out && !op_erase_reg |-> op_cnt_reg <= PROG_MAX_CYCLES)
    else $error("Program overran its maximum time.");
  op_overhead_a: assert property (@(posedge clk_in) disable iff (rst_in)
    op_done_out |-> op_cnt_reg == (op_erase_reg ? ERASE_CYCLES + PAGE_WORDS : PROG_CYCLES + 1))
    else $error("Operation overhead not as designed.");
  refuse_pulse_a: assert property (@(posedge clk_in) disable iff (rst_in)
    op_reject_out |=> !op_reject_out)
    else $error("Refusal pulse longer than one cycle.");

  hit_c: cover property (@(posedge clk_in) disable iff (rst_in) rd_hit);
  reject_c: cover property (@(posedge clk_in) disable iff (rst_in) op_reject_out);
  erase_done_c: cover property (@(posedge clk_in) disable iff (rst_in) op_done_out && op_erase_reg);
  read_during_op_c: cover property (@(posedge clk_in) disable iff (rst_in) rd_valid_out && op_busy_out);

endmodule

/* hw/flash_ctrl_pkg.sv */
/*
  Shared constants and state types for the program Flash access controller.
  Assumes a 250 MHz system clock; all times below are converted to cycles of it.
*/
package flash_ctrl_pkg;

  // ----------------------------------------
  // System clock
  // ----------------------------------------
  localparam int CLK_KHZ = 250000;

  // ----------------------------------------
  // Wait-state requirements by system clock
  // ----------------------------------------
  localparam logic [7:0] WS_LIMIT1_MHZ = 8'h08;
  localparam logic [7:0] WS_LIMIT2_MHZ = 8'h0D;
  localparam logic [7:0] WS_LIMIT3_MHZ = 8'h11;
  localparam logic [3:0] WS_MIN1 = 4'h1;
  localparam logic [3:0] WS_MIN2 = 4'h2;
  localparam logic [3:0] WS_MIN3 = 4'h3;
  localparam logic [3:0] WS_MIN4 = 4'h4;

  // ----------------------------------------
  // Read pipeline figures
  // ----------------------------------------
  localparam int MISS_OVERHEAD = 2;

  // ----------------------------------------
  // Program and erase timing
  // ----------------------------------------
  localparam real ERASE_TYP_MS = 7.0;
  localparam real ERASE_MAX_MS = 8.0;
  localparam real PROG_TYP_MS = 3.0;
  localparam real PROG_MAX_MS = 3.5;
  localparam int ERASE_TYP_CYCLES = int'(ERASE_TYP_MS * CLK_KHZ);
  localparam int ERASE_MAX_CYCLES = int'($floor(ERASE_MAX_MS * CLK_KHZ));
  localparam int PROG_TYP_CYCLES = int'(PROG_TYP_MS * CLK_KHZ);
  localparam int PROG_MAX_CYCLES = int'($floor(PROG_MAX_MS * CLK_KHZ));
  localparam int TIMER_W = 21;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_ISSUE = 2'b10,
    RD_CAPTURE = 2'b11
  } rd_state_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_TIME = 2'b01,
    OP_WRITE = 2'b10
  } op_state_t;

endpackage

/* hw/flash_bank_mem.sv */
/*
  One Flash module's storage array: single port, registered read data.
  Assumes the controller never reads and writes the same cycle.
*/
`timescale 1ns/1ps
module flash_bank_mem #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  // Clock
  input wire logic clk_in,
  // Access port
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [2**AW];

  // Shipped state: every word erased.
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = '1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (en_in && we_in) begin
      mem[addr_in] <= wdata_in;
    end
    if (en_in && !we_in) begin
      rdata_out <= mem[addr_in];
    end
  end

endmodule

/* verif/cpu_fetch_model.sv */
/*
  Behavioural CPU fetch master for the Flash read port.
  Assumes the bench calls fetch() and nothing else drives the read request.
*/
`timescale 1ns/1ps
module cpu_fetch_model #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  // Clock
  input wire logic clk_in,
  // Read port
  input wire logic rd_ready_in,
  input wire logic rd_valid_in,
  input wire logic [DATA_W-1:0] rd_data_in,
  output logic rd_req_out,
  output logic [ADDR_W-1:0] rd_addr_out
);
  // ----------------------------------------
  // Fetch cycle
  // ----------------------------------------
  initial begin
    rd_req_out = 1'b0;
    rd_addr_out = '0;
  end

  // The idle address is inverted so a stale address is never mistaken for a held request.
  task automatic fetch(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data, output int lat);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    rd_req_out = 1'b1;
    rd_addr_out = addr;
    while (rd_ready_in !== 1'b1 && n < 1000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    @(posedge clk_in);
    #1;
    rd_req_out = 1'b0;
    rd_addr_out = ~addr;
    // A hit answers on the taking edge itself, so valid is looked at before waiting for another edge.
    lat = 1;
    while (rd_valid_in !== 1'b1 && lat < 1000) begin
      @(posedge clk_in);
      #1;
      lat++;
    end
    data = rd_data_in;
  endtask
endmodule

/* verif/flash_access_and_program_control_tb_top.sv */
/*
  Self-checking bench for the Flash access controller with a CPU fetch model.
  Assumes short program and erase counts; the operation lengths and the erase-read latency derive from them.
*/
`timescale 1ns/1ps
module flash_access_and_program_control_tb_top;
  import flash_ctrl_pkg::*;

  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int ERASE_C = 20;
  localparam int PROG_C = 10;
  localparam int PAGE_W = 5;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] PAT = 32'hA5C3_0F96;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] ws = 4'h4;
  logic [7:0] mhz = 8'hFA;
  logic ws_low;
  logic rd_req;
  logic [11:0] rd_addr;
  logic rd_ready;
  logic rd_valid;
  logic [31:0] rd_data;
  logic op_req = 1'b0;
  logic op_erase = 1'b0;
  logic [11:0] op_addr = 12'h000;
  logic [31:0] op_data = 32'h0000_0000;
  logic op_busy;
  logic op_done;
  logic op_reject;
  int n_errors = 0;
  int samples_checked = 0;

  always #2 clk_in = ~clk_in;

  flash_access_ctrl #(.ADDR_W(12), .DATA_W(32), .PAGE_W(PAGE_W), .ERASE_CYCLES(ERASE_C), .PROG_CYCLES(PROG_C))
    flash_access_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .flash_wait_state_count_in(ws),
    .sys_clk_mhz_in(mhz), .ws_too_low_out(ws_low), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
    .rd_ready_out(rd_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .op_req_in(op_req),
    .op_erase_in(op_erase), .op_addr_in(op_addr), .op_data_in(op_data), .op_busy_out(op_busy),
    .op_done_out(op_done), .op_reject_out(op_reject));

  cpu_fetch_model #(.ADDR_W(12), .DATA_W(32)) cpu_fetch_model_inst (.clk_in(clk_in), .rd_ready_in(rd_ready),
    .rd_valid_in(rd_valid), .rd_data_in(rd_data), .rd_req_out(rd_req), .rd_addr_out(rd_addr));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Assumes the engine is idle, so the request is taken at the first edge.
  task automatic op_run(input logic erase, input logic [11:0] addr, input logic [31:0] data, output int lat,
                        output logic rej);
    @(posedge clk_in);
    #1;
    op_req = 1'b1;
    op_erase = erase;
    op_addr = addr;
    op_data = data;
    @(posedge clk_in);
    #1;
    op_req = 1'b0;
    op_addr = ~addr;
    op_data = ~data;
    // A refusal pulse stands only in the cycle after the taking edge, so it is looked at at once.
    lat = 1;
    rej = (op_reject === 1'b1);
    while (op_done !== 1'b1 && rej !== 1'b1 && lat < 5000) begin
      @(posedge clk_in);
      #1;
      lat++;
      rej = (op_reject === 1'b1);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values();
    check(rd_ready, 1'b1);
    check(rd_valid, 1'b0);
    check(rd_data, 32'h0000_0000);
    check({op_busy, op_done, op_reject, ws_low}, 4'h0);
  endtask

  task automatic ws_table();
    logic [7:0] f [9] = '{8'h08, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h12, 8'hFA};
    logic [3:0] w [9] = '{4'h1, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4};
    logic e [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 9; i++) begin
      mhz = f[i];
      ws = w[i];
      repeat (3) @(posedge clk_in);
      #1;
      check(ws_low, e[i]);
    end
  endtask

  task automatic miss_latency();
    logic [31:0] d;
    int lat;
    for (int w = 1; w <= 4; w++) begin
      ws = 4'(w);
      cpu_fetch_model_inst.fetch(12'(16 + 64 * w), d, lat);
      check(lat, w + 3);
      check(d, ONES);
    end
  endtask

  // Module 1 is programmed while module 0 keeps serving, then read back through a prefetch hit.
  task automatic program_beside_reads();
    logic [31:0] d;
    int lat;
    int olat;
    logic rej;
    ws = 4'h2;
    cpu_fetch_model_inst.fetch(12'h020, d, lat);
    fork
      op_run(1'b0, 12'h845, PAT, olat, rej);
      begin
        repeat (3) @(posedge clk_in);
        cpu_fetch_model_inst.fetch(12'h300, d, lat);
        check(lat, 5);
      end
    join
    check(rej, 1'b0);
    check(olat, PROG_C + 2);
    check(op_busy, 1'b0);
    cpu_fetch_model_inst.fetch(12'h844, d, lat);
    repeat (10) @(posedge clk_in);
    cpu_fetch_model_inst.fetch(12'h845, d, lat);
    check(lat, 1);
    check(d, PAT);
  endtask

  task automatic reject_serving();
    int olat;
    logic rej;
    op_run(1'b0, 12'h846, PAT, olat, rej);
    check(rej, 1'b1);
    check(olat, 1);
    check(op_busy, 1'b0);
  endtask

  // The page under erase is read meanwhile; that read is held until the erase has finished.
  task automatic erase_beside_reads();
    logic [31:0] d;
    int lat;
    int olat;
    logic rej;
    cpu_fetch_model_inst.fetch(12'h400, d, lat);
    fork
      op_run(1'b1, 12'h845, PAT, olat, rej);
      begin
        repeat (3) @(posedge clk_in);
        cpu_fetch_model_inst.fetch(12'h845, d, lat);
        check(lat, ERASE_C + (1 << PAGE_W));
        check(d, ONES);
      end
    join
    check(rej, 1'b0);
    check(olat, ERASE_C + (1 << PAGE_W) + 1);
    cpu_fetch_model_inst.fetch(12'h845, d, lat);
    check(d, ONES);
    check(lat, 5);
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (19) @(posedge clk_in);
    #1;
    reset_values();
    @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    ws_table();
    miss_latency();
    program_beside_reads();
    reject_serving();
    erase_beside_reads();
    results();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #40000;
    n_errors++;
    $display("Error %0t: watchdog expired", $time);
    results();
  end
endmodule
